// File: core/pcd_pkg.sv
package pcd_pkg;

  // Clock rate and timing figures
  localparam int CLK_HZ = 40_000_000;
  localparam int LATCH_TIMEOUT_US = 500;
  localparam int OFF_TIMEOUT_US = 500;
  localparam int LATCH_TIMEOUT_CYC = (LATCH_TIMEOUT_US * (CLK_HZ / 1_000_000));
  localparam int OFF_TIMEOUT_CYC = (OFF_TIMEOUT_US * (CLK_HZ / 1_000_000));

  // Code and level widths
  localparam int CODE_W = 5;
  localparam int PCT_W = 7;
  localparam int TMR_W = 16;
  localparam logic [CODE_W-1:0] CODE_FULL = 5'h00;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
  localparam logic [CODE_W-1:0] CODE_STEP = 5'h01;
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;

  // Brightness table, index is code minus one (100% down to 2%)
  localparam logic [PCT_W-1:0] PCT_TABLE [32] = '{
    7'd100, 7'd97, 7'd94, 7'd90, 7'd87, 7'd84, 7'd81, 7'd77,
    7'd74, 7'd71, 7'd68, 7'd65, 7'd61, 7'd58, 7'd55, 7'd52,
    7'd48, 7'd45, 7'd42, 7'd39, 7'd35, 7'd32, 7'd29, 7'd26,
    7'd23, 7'd19, 7'd16, 7'd13, 7'd10, 7'd6, 7'd3, 7'd2};

  // Link states
  typedef enum logic [2:0] {
    PCD_OFF = 3'b001,
    PCD_BURST = 3'b010,
    PCD_HOLD = 3'b100
  } pcd_state_t;

  // Protection inputs grouped
  typedef struct packed {
    logic ovp_high;
    logic ovp_low;
    logic temp_high;
    logic temp_cool;
  } pcd_prot_t;

endpackage

// File: core/pcd_timer.sv
`timescale 1ns/1ps
// Down counter that restarts on load and flags expiry once
module pcd_timer import pcd_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic run_i,
  input wire logic [TMR_W-1:0] count_i,
  output logic expired_o
);
  logic [TMR_W-1:0] cnt_r;
  wire logic at_one = (cnt_r == TMR_ONE);

  // Counter, load has priority over counting
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= TMR_ZERO;
      expired_o <= 1'b0;
    end else if (ce_i) begin
      expired_o <= 1'b0;
      if (load_i) begin
        cnt_r <= count_i;
      end else if (run_i && cnt_r != TMR_ZERO) begin
        cnt_r <= cnt_r - TMR_ONE;
        expired_o <= at_one;
      end
    end
  end
endmodule // pcd_timer

// File: core/pcd_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Count rising edges into 32 levels
// - Count one full scale, thirty-two two percent
// - Edge counter wraps modulo 32
// - Accept 1MHz edges, hide intermediate counts
// - First edge enables, full scale after timeout
// - Low for off timeout disables switching
// - Every edge restarts latch timing
// - Code maps to table percentages
// - Over-temperature stops switch, hysteretic recovery
// - Over-voltage stops switching until lower threshold
module pcd_ctrl import pcd_pkg::*; (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  // Control wire from host
  input wire logic CTRL_WIRE_I,
  // Analog comparator flags
  input wire pcd_prot_t PROT_I,
  // Converter control
  output logic ENABLE_O,
  output logic SWITCH_EN_O,
  output logic [PCT_W-1:0] LEVEL_PCT_O,
  output logic [CODE_W-1:0] CODE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser
  logic sync1_r; // First stage, read only by second
  logic sync2_r;
  logic prev_r;  // Previous sampled level for edge detect

  // Two-flop synchroniser and edge history
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (CE_I) begin
      sync1_r <= CTRL_WIRE_I;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Rising edge of the cleaned wire; at 40MHz a 100ns high is 4 samples
  wire logic rise = sync2_r & ~prev_r;
  wire logic wire_low = ~sync2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Timers
  logic lat_exp;
  logic off_exp;
  pcd_state_t state_r, state_nxt;

  // Latch timer reloads on every edge
  pcd_timer u_lat (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .ce_i(CE_I),
    .load_i(rise),
    .run_i(state_r == PCD_BURST),
    .count_i(TMR_W'(LATCH_TIMEOUT_CYC)),
    .expired_o(lat_exp)
  );

  // Off timer reloads whenever the wire is high
  pcd_timer u_off (
    .clk_i(CLK_I),
    .rst_n_i(RESETN_I),
    .ce_i(CE_I),
    .load_i(sync2_r),
    .run_i(wire_low && state_r != PCD_OFF),
    .count_i(TMR_W'(OFF_TIMEOUT_CYC)),
    .expired_o(off_exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge counter and state
  logic [CODE_W-1:0] cnt_r;   // Running count minus one
  logic [CODE_W-1:0] cnt_nxt;
  logic [CODE_W-1:0] code_nxt;

  // Latch only on a cycle with no edge; an edge landing on expiry must restart timing
  wire logic latch_now = lat_exp && !rise && (state_r == PCD_BURST);

  // First edge after off starts at code 1, later edges step and wrap at 32
  assign cnt_nxt = (state_r == PCD_OFF) ? CODE_FULL : cnt_r + CODE_STEP;

  // State transitions
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PCD_OFF: begin
        if (rise) state_nxt = PCD_BURST;
      end
      PCD_BURST: begin
        if (off_exp) state_nxt = PCD_OFF;
        else if (latch_now) state_nxt = PCD_HOLD;
      end
      PCD_HOLD: begin
        if (off_exp) state_nxt = PCD_OFF;
        else if (rise) state_nxt = PCD_BURST;
      end
      default: state_nxt = PCD_OFF;
    endcase
  end

  // Applied code only changes when the latch timer runs out
  assign code_nxt = latch_now ? cnt_r : CODE_O;

  // Protection gating, each flag hysteretic
  logic ovp_r;
  logic otp_r;
  wire logic ovp_nxt = PROT_I.ovp_high ? 1'b1 : (PROT_I.ovp_low ? 1'b0 : ovp_r);
  wire logic otp_nxt = PROT_I.temp_high ? 1'b1 : (PROT_I.temp_cool ? 1'b0 : otp_r);
  wire logic en_nxt = (state_nxt != PCD_OFF);

  // Main registers
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r <= PCD_OFF;
      cnt_r <= CODE_FULL;
      CODE_O <= CODE_FULL;
      LEVEL_PCT_O <= PCT_FULL;
      ENABLE_O <= 1'b0;
      SWITCH_EN_O <= 1'b0;
      ovp_r <= 1'b0;
      otp_r <= 1'b0;
    end else if (CE_I) begin
      state_r <= state_nxt;
      if (rise) cnt_r <= cnt_nxt;
      CODE_O <= code_nxt;
      LEVEL_PCT_O <= PCT_TABLE[code_nxt];
      ENABLE_O <= en_nxt;
      SWITCH_EN_O <= en_nxt && !ovp_nxt && !otp_nxt;
      ovp_r <= ovp_nxt;
      otp_r <= otp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Cycles since the last detected edge, saturating; checks latch timing independently
  logic [TMR_W-1:0] quiet_r;
  wire logic quiet_max = (quiet_r == TMR_W'(LATCH_TIMEOUT_CYC));
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      quiet_r <= TMR_ZERO;
    end else if (CE_I) begin
      if (rise) quiet_r <= TMR_ZERO;
      else if (!quiet_max) quiet_r <= quiet_r + TMR_ONE;
    end
  end

  sequence s_burst_done;
    $rose(lat_exp) && latch_now;
  endsequence

  // Edge taken while the part is not being shut down
  sequence s_edge_taken;
    CE_I && rise && !off_exp;
  endsequence

  a_code_latch: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && latch_now |=> CODE_O == $past(cnt_r))
    else $error("code not latched at timeout");

  a_code_steady: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && !latch_now |=> $stable(CODE_O))
    else $error("code changed outside latch");

  a_first_edge: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && state_r == PCD_OFF && rise |=> ENABLE_O && cnt_r == CODE_FULL)
    else $error("first edge did not enable at code one");

  a_wrap_count: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && rise && state_r != PCD_OFF && (&cnt_r) |=> cnt_r == CODE_FULL)
    else $error("counter did not wrap");

  a_off_disable: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && off_exp |=> !ENABLE_O && !SWITCH_EN_O)
    else $error("off timeout did not disable");

  a_ovp_stop: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && PROT_I.ovp_high |=> !SWITCH_EN_O)
    else $error("switching during over-voltage");

  a_otp_stop: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && PROT_I.temp_high |=> !SWITCH_EN_O)
    else $error("switching during over-temperature");

  a_level_map: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I and s_burst_done) |=> LEVEL_PCT_O == PCT_TABLE[$past(cnt_r)])
    else $error("level does not match code");

  a_sync_delay: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I ##1 CE_I |-> sync2_r == $past(sync1_r))
    else $error("synchroniser skipped a stage");

  a_latch_quiet: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && latch_now |-> quiet_max)
    else $error("code latched before the wire went quiet");

  a_edge_restart: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    s_edge_taken |=> state_r == PCD_BURST && ENABLE_O)
    else $error("edge did not restart latch timing");

  a_off_quiet: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && state_r == PCD_OFF && !rise |=> !ENABLE_O && !SWITCH_EN_O)
    else $error("switching while disabled");

  a_ovp_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && ovp_r && !PROT_I.ovp_low |=> !SWITCH_EN_O)
    else $error("switching resumed above the lower threshold");

  a_otp_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CE_I && otp_r && !PROT_I.temp_cool |=> !SWITCH_EN_O)
    else $error("switching resumed before cooling");

endmodule // pcd_ctrl

// File: bench/pcd_host.sv
`timescale 1ns/1ps
// Host pin model, push-pull, so the wire always has a level
module pcd_host (
  // Clock
  input wire logic clk_i,
  // Control wire to device
  output logic wire_o
);
  // Idle low keeps the device off
  initial wire_o = 1'b0;
  // One burst of n edges, low lo cycles then high 20 cycles each
  task automatic burst(input int n, input int lo);
    for (int k = 0; k < n; k++) begin
      wire_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
      wire_o <= 1'b1;
      repeat (20) @(posedge clk_i);
    end
  endtask
  // Drop the wire and leave it low
  task automatic release_wire();
    wire_o <= 1'b0;
  endtask
endmodule // pcd_host

// File: bench/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the dimming control
module testbench import pcd_pkg::*; ();
  // Stimulus and observed outputs
  logic clk, rst_n, ce, en, sw;
  pcd_prot_t prot;
  logic ctrl_wire;
  logic [PCT_W-1:0] pct;
  logic [CODE_W-1:0] code;
  // Counters
  int miscompares, check_count, cyc;
  //////////////////////////////////////////////////////////////////////
  pcd_ctrl u_pcd_ctrl (.CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .CTRL_WIRE_I(ctrl_wire), .PROT_I(prot),
    .ENABLE_O(en), .SWITCH_EN_O(sw), .LEVEL_PCT_O(pct), .CODE_O(code));
  pcd_host host (.clk_i(clk), .wire_o(ctrl_wire));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, well above the four long timeouts
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      miscompares++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Compare with four-state equality
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Old code must survive the burst, new code after the timeout
  task latch_check(input logic [4:0] old_c, input logic [4:0] new_c, input logic [6:0] new_p);
    repeat (19850) @(posedge clk);
    check({3'h0, code}, {3'h0, old_c});
    repeat (200) @(posedge clk);
    check({3'h0, code}, {3'h0, new_c});
    check({1'h0, pct}, {1'h0, new_p});
  endtask
  // Outputs held in reset state
  task t_reset();
    check({6'h00, en, sw}, 8'h00);
    check({1'h0, pct}, 8'h64);
  endtask
  // First edge enables at once; 17 edges give the 48 percent step
  task t_first();
    host.burst(1, 20);
    check({6'h00, en, sw}, 8'h03);
    host.burst(16, 20);
    latch_check(5'h00, 5'h10, 7'h30);
  endtask
  // Slow edges within the latch timeout reach count 32, one more wraps to full scale
  task t_wrap();
    host.burst(15, 200);
    latch_check(5'h10, 5'h1F, 7'h02);
    host.burst(1, 20);
    latch_check(5'h1F, 5'h00, 7'h64);
  endtask
  // Over-voltage then over-temperature, each with hysteresis
  task t_prot();
    // Frozen clock enable ignores the comparator
    ce <= 1'b0;
    prot <= pcd_prot_t'(4'h8);
    repeat (3) @(posedge clk);
    check({7'h00, sw}, 8'h01);
    prot <= pcd_prot_t'(4'h0);
    ce <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      prot <= pcd_prot_t'(4'h8 >> (2 * i));
      @(posedge clk);
      prot <= pcd_prot_t'(4'h0);
      repeat (3) @(posedge clk);
      check({6'h00, en, sw}, 8'h02);
      prot <= pcd_prot_t'(4'h4 >> (2 * i));
      @(posedge clk);
      prot <= pcd_prot_t'(4'h0);
      repeat (3) @(posedge clk);
      check({7'h00, sw}, 8'h01);
    end
  endtask
  // Low wire shuts down only after the off timeout
  task t_off();
    host.release_wire();
    repeat (19900) @(posedge clk);
    check({7'h00, en}, 8'h01);
    repeat (200) @(posedge clk);
    check({6'h00, en, sw}, 8'h00);
  endtask
  // Verdict and end of run
  task close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    prot = pcd_prot_t'(4'h0);
    miscompares = 0;
    check_count = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    t_reset();
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_first();
    t_prot();
    t_wrap();
    t_off();
    close_out();
  end
endmodule // testbench
